/* File: mmr_regs.svh */
`ifndef MMR_REGS_SVH
`define MMR_REGS_SVH

// byte offsets on the register bus
`define MMR_MISC_OFS     12'h000
`define MMR_TEST0_OFS    12'h004
`define MMR_TEST1_OFS    12'h008
`define MMR_MEMSIZ_OFS   12'h00c
`define MMR_RAMPOS_OFS   12'h010

// field positions
`define MMR_MISC_STR     3:2
`define MMR_MISC_UPPER   1
`define MMR_MISC_ENABLE  0
`define MMR_RAMPOS_HAL   0
`define MMR_RAMPOS_ADDR  7:3

// reset and read values
`define MMR_MISC_RST     8'h0d
`define MMR_RAMPOS_RST   8'h09
`define MMR_RAMPOS_MASK  8'hf9
`define MMR_TEST_RD      8'h00

// RAM mappable region masks per allocation code
`define MMR_MASK_2K      16'hf800
`define MMR_MASK_4K      16'hf000
`define MMR_MASK_8K      16'he000
`define MMR_MASK_16K     16'hc000

`endif

/* File: mmr_pkg.sv */
package mmr_pkg;

  typedef enum logic [2:0] {
    MMR_MODE_NORM_SINGLE,
    MMR_MODE_NORM_EXP,
    MMR_MODE_EMUL_SINGLE,
    MMR_MODE_EMUL_EXP,
    MMR_MODE_SPEC_SINGLE,
    MMR_MODE_SPEC_EXP,
    MMR_MODE_PERIPH,
    MMR_MODE_SPEC_TEST
  } mmr_mode_t;

  typedef struct packed {
    logic       zero;
    logic [1:0] eeprom_alloc_field;
    logic [2:0] ram_alloc_field;
    logic       register_space_size_switch;
  } mmr_size_sw_t;

  typedef struct packed {
    logic [3:0] zero;
    logic [1:0] external_stretch_field;
    logic       upper_half_only_bit;
    logic       program_memory_enable_bit;
  } mmr_misc_t;

endpackage

/* File: mmr_ram_map.sv */
`timescale 1ns/1ps
`include "mmr_regs.svh"

module mmr_ram_map (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // configuration
  input  wire logic [7:0]  ram_position_in,
  input  wire logic [2:0]  ram_alloc_in,
  // placement
  output logic      [15:0] ram_base_out
);

  wire        hal = ram_position_in[`MMR_RAMPOS_HAL];
  wire [15:0] region_mask;
  wire [15:0] region_base;
  wire [15:0] region_size;
  wire [3:0]  alloc_units;
  wire [15:0] alloc_size;
  wire [15:0] high_offset;
  wire [15:0] next_base;

  // fewer position bits are honoured as the region grows
  assign region_mask = (ram_alloc_in == 3'h0) ? `MMR_MASK_2K :
                       (ram_alloc_in == 3'h1) ? `MMR_MASK_4K :
                       (ram_alloc_in[2] == 1'b0) ? `MMR_MASK_8K :
                       `MMR_MASK_16K;
  assign region_base = {ram_position_in[`MMR_RAMPOS_ADDR], 11'h000} & region_mask;
  assign region_size = (~region_mask) + 16'h0001;
  assign alloc_units = {1'b0, ram_alloc_in} + 4'h1;
  assign alloc_size  = {1'b0, alloc_units, 11'h000};
  assign high_offset = region_size - alloc_size;
  assign next_base   = region_base + (hal ? high_offset : 16'h0000);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_base_out <= 16'h0000;
    end else begin
      ram_base_out <= next_base;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  base_low_align_a: assert property (
    !hal |=> ram_base_out == $past(region_base))
    else $error("low-aligned RAM base is not the region base");

  base_reset_a: assert property (
    rst_n_in && (ram_position_in == `MMR_RAMPOS_RST) && (ram_alloc_in == 3'h4)
      |=> ram_base_out == 16'h1800)
    else $error("RAM reset base wrong for code 100");

endmodule

/* File: mmr_top.sv */
`timescale 1ns/1ps
`include "mmr_regs.svh"

module mmr_top (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_n_in,
  // operating mode and integration straps
  input  wire mmr_pkg::mmr_mode_t   mode_in,
  input  wire mmr_pkg::mmr_size_sw_t size_switch_in,
  input  wire logic                 program_memory_enable_strap_in,
  // apb slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [11:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  input  wire logic [3:0]           pstrb_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // external bus timing
  output logic      [1:0]           stretch_cycles_out,
  // program memory visibility
  output logic                      program_memory_mapped_out,
  output logic                      lower_half_program_ok_out,
  output logic                      page_window_program_ok_out,
  // RAM placement
  output logic      [15:0]          ram_base_out,
  output logic                      ram_high_align_out
);

  import mmr_pkg::*;

  mmr_misc_t  misc;
  mmr_misc_t  next_misc;
  logic       misc_lock;
  logic [7:0] ram_position;
  logic       ram_lock;
  logic       strap_loaded;
  logic [7:0] ram_position_eff;

  // bus phase decode
  wire setup_phase  = psel_in & ~penable_in;
  wire access_phase = psel_in & penable_in;
  wire bus_write    = access_phase & pwrite_in & pstrb_in[0];

  // address decode
  wire sel_misc   = (paddr_in == `MMR_MISC_OFS);
  wire sel_test0  = (paddr_in == `MMR_TEST0_OFS);
  wire sel_test1  = (paddr_in == `MMR_TEST1_OFS);
  wire sel_memsiz = (paddr_in == `MMR_MEMSIZ_OFS);
  wire sel_rampos = (paddr_in == `MMR_RAMPOS_OFS);
  wire sel_any    = sel_misc | sel_test0 | sel_test1 | sel_memsiz | sel_rampos;

  // mode classes
  wire special_mode = (mode_in == MMR_MODE_SPEC_SINGLE) |
                      (mode_in == MMR_MODE_SPEC_EXP) |
                      (mode_in == MMR_MODE_PERIPH) |
                      (mode_in == MMR_MODE_SPEC_TEST);
  // single-chip and peripheral modes have no external space to stretch
  wire external_mode = (mode_in == MMR_MODE_NORM_EXP) |
                       (mode_in == MMR_MODE_EMUL_EXP) |
                       (mode_in == MMR_MODE_SPEC_EXP) |
                       (mode_in == MMR_MODE_SPEC_TEST);

  // write acceptance: once after reset unless special
  wire misc_write   = bus_write & sel_misc;
  wire misc_accept  = misc_write & (special_mode | ~misc_lock);
  wire rampos_write = bus_write & sel_rampos;
  wire rampos_accept = rampos_write & (special_mode | ~ram_lock);

  // test and size registers take no write at all
  assign next_misc = mmr_misc_t'({4'h0, pwdata_in[3:0]});

  // code n stretches by n bus cycles, so the code passes straight through
  wire [1:0] stretch_code = external_mode ? misc.external_stretch_field : 2'h0;

  // read selection
  wire [7:0] memsiz_value = {size_switch_in.register_space_size_switch,
                             1'b0,
                             size_switch_in.eeprom_alloc_field,
                             1'b0,
                             size_switch_in.ram_alloc_field};
  wire [7:0] test_value   = `MMR_TEST_RD;
  wire [7:0] read_value   = sel_misc   ? misc :
                            sel_memsiz ? memsiz_value :
                            sel_rampos ? ram_position :
                            (sel_test0 | sel_test1) ? test_value :
                            8'h00;

  // zero-wait slave: data is latched in setup so the access edge completes
  assign pready_out  = 1'b1;
  assign pslverr_out = access_phase & ~sel_any;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite_in) begin
      prdata_out <= {24'h00_0000, read_value};
    end
  end

  // enable bit is a strap, so it is caught one edge after release
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_loaded <= 1'b0;
    end else begin
      strap_loaded <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      misc <= mmr_misc_t'(`MMR_MISC_RST);
    end else if (!strap_loaded) begin
      misc.program_memory_enable_bit <= program_memory_enable_strap_in;
    end else if (misc_accept) begin
      misc <= next_misc;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      misc_lock <= 1'b0;
    end else if (misc_accept & ~special_mode) begin
      misc_lock <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_position <= `MMR_RAMPOS_RST;
    end else if (rampos_accept) begin
      ram_position <= pwdata_in[7:0] & `MMR_RAMPOS_MASK;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_lock <= 1'b0;
    end else if (rampos_accept & ~special_mode) begin
      ram_lock <= 1'b1;
    end
  end

  // effective stage: the mapping logic sees a write one edge late
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stretch_cycles_out <= 2'h0;
      program_memory_mapped_out <= 1'b0;
      lower_half_program_ok_out <= 1'b0;
      page_window_program_ok_out <= 1'b0;
      ram_position_eff <= `MMR_RAMPOS_RST;
      ram_high_align_out <= 1'b0;
    end else begin
      stretch_cycles_out <= stretch_code;
      program_memory_mapped_out <= misc.program_memory_enable_bit;
      lower_half_program_ok_out <= misc.program_memory_enable_bit &
                                   ~misc.upper_half_only_bit;
      // the window ignores the upper-half bit
      page_window_program_ok_out <= misc.program_memory_enable_bit;
      ram_position_eff <= ram_position;
      ram_high_align_out <= ram_position[`MMR_RAMPOS_HAL];
    end
  end

  // base lands two edges after a position write: placement is computed
  // from the effective copy, trading one cycle for a short decode path
  mmr_ram_map u_ram_map (
    .clock_in        (clock_in),
    .rst_n_in        (rst_n_in),
    .ram_position_in (ram_position_eff),
    .ram_alloc_in    (size_switch_in.ram_alloc_field),
    .ram_base_out    (ram_base_out)
  );

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence misc_written_s;
    misc_accept && external_mode;
  endsequence

  sequence mode_held_s;
    $stable(mode_in) [*2];
  endsequence

  stretch_delay_a: assert property (
    misc_written_s ##0 mode_held_s
      |=> stretch_cycles_out == $past(pwdata_in[`MMR_MISC_STR], 2))
    else $error("stretch not effective one cycle after write");

  stretch_early_a: assert property (
    misc_accept && external_mode && $stable(mode_in)
      |=> stretch_cycles_out == $past(misc.external_stretch_field))
    else $error("stretch changed in the write cycle");

  stretch_off_a: assert property (
    !$past(external_mode) |-> stretch_cycles_out == 2'h0)
    else $error("stretch applied outside external modes");

  write_once_a: assert property (
    misc_write && misc_lock && !special_mode |=> $stable(misc))
    else $error("locked control register changed");

  special_write_a: assert property (
    misc_write && special_mode && strap_loaded
      |=> misc == $past(next_misc))
    else $error("special mode write lost");

  lower_block_a: assert property (
    misc.upper_half_only_bit |=> !lower_half_program_ok_out)
    else $error("lower half program memory not blocked");

  window_reach_a: assert property (
    misc.program_memory_enable_bit && misc.upper_half_only_bit
      |=> page_window_program_ok_out && !lower_half_program_ok_out)
    else $error("window lost with upper-half-only set");

  map_remove_a: assert property (
    !misc.program_memory_enable_bit
      |=> !program_memory_mapped_out && !page_window_program_ok_out)
    else $error("program memory left in map");

  reset_value_a: assert property (
    $rose(strap_loaded) |-> misc.external_stretch_field == 2'h3 &&
      !misc.upper_half_only_bit &&
      misc.program_memory_enable_bit == $past(program_memory_enable_strap_in))
    else $error("control register reset value wrong");

  test_read_a: assert property (
    setup_phase && !pwrite_in && (sel_test0 || sel_test1)
      |=> prdata_out == 32'h0000_0000)
    else $error("test register read not zero");

  size_mirror_a: assert property (
    setup_phase && !pwrite_in && sel_memsiz
      |=> prdata_out[7:0] == $past(memsiz_value) && prdata_out[6] == 1'b0
          && prdata_out[3] == 1'b0)
    else $error("size register does not mirror switches");

  lock_clear_a: assert property (
    !strap_loaded |-> !misc_lock)
    else $error("lock set right after reset");

  // the flops are still held on the release edge, so checks that expect
  // live outputs wait for the strap load
  map_present_a: assert property (
    strap_loaded && misc.program_memory_enable_bit |=> program_memory_mapped_out)
    else $error("program memory missing from map");

  window_on_a: assert property (
    strap_loaded && misc.program_memory_enable_bit |=> page_window_program_ok_out)
    else $error("program page window closed while memory enabled");

  lower_open_a: assert property (
    strap_loaded && misc.program_memory_enable_bit && !misc.upper_half_only_bit
      |=> lower_half_program_ok_out)
    else $error("lower half program memory blocked while allowed");

  stretch_code_a: assert property (
    strap_loaded && external_mode
      |=> stretch_cycles_out == $past(misc.external_stretch_field))
    else $error("stretch output does not follow the stretch code");

  lock_set_a: assert property (
    misc_accept && !special_mode |=> misc_lock)
    else $error("first write did not lock the control register");

  lock_hold_a: assert property (
    misc_lock |=> misc_lock)
    else $error("control register lock dropped without reset");

  special_free_a: assert property (
    special_mode && !misc_lock |=> !misc_lock)
    else $error("special mode write locked the control register");

  ro_write_a: assert property (
    strap_loaded && bus_write && (sel_test0 || sel_test1)
      |=> $stable(misc) && $stable(misc_lock) && $stable(ram_position))
    else $error("test register write changed state");

  size_write_a: assert property (
    strap_loaded && bus_write && sel_memsiz
      |=> $stable(misc) && $stable(misc_lock) && $stable(ram_position))
    else $error("size register write changed state");

  size_reg_bit_a: assert property (
    setup_phase && !pwrite_in && sel_memsiz
      |=> prdata_out[7] == $past(size_switch_in.register_space_size_switch))
    else $error("register space bit wrong");

  size_eeprom_a: assert property (
    setup_phase && !pwrite_in && sel_memsiz
      |=> prdata_out[5:4] == $past(size_switch_in.eeprom_alloc_field))
    else $error("eeprom allocation field wrong");

  size_ram_a: assert property (
    setup_phase && !pwrite_in && sel_memsiz
      |=> prdata_out[2:0] == $past(size_switch_in.ram_alloc_field))
    else $error("ram allocation field wrong");

  misc_high_zero_a: assert property (
    setup_phase && !pwrite_in && sel_misc |=> prdata_out[7:4] == 4'h0)
    else $error("control register upper bits not zero");

endmodule

/* File: tb_memory_map_misc_and_size_regs.sv */
`timescale 1ns/1ps
module tb_memory_map_misc_and_size_regs;
  import mmr_pkg::*;
  logic         clock_in;
  logic         rst_n_in;
  logic         strap;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [1:0]   stretch;
  logic         mapped;
  logic         lower_ok;
  logic         window_ok;
  logic [15:0]  ram_base;
  logic         high_align;
  logic [4:0]   outs_vec;
  mmr_mode_t    mode;
  mmr_size_sw_t sw;
  logic [7:0]   misc_m;
  bit           locked;
  int           n_errors = 0;
  int           check_count = 0;
  logic [15:0]  base_tab [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000,
                                 16'h1800, 16'h1000, 16'h0800, 16'h0000};
  logic [11:0]  ro_addr [3] = '{12'h004, 12'h008, 12'h00c};
  int           region_tab [8] = '{2048, 4096, 8192, 8192, 16384, 16384, 16384, 16384};

  assign outs_vec = {stretch, mapped, lower_ok, window_ok};

  mmr_top dut (
    .clock_in                       (clock_in),
    .rst_n_in                       (rst_n_in),
    .mode_in                        (mode),
    .size_switch_in                 (sw),
    .program_memory_enable_strap_in (strap),
    .psel_in                        (psel),
    .penable_in                     (penable),
    .pwrite_in                      (pwrite),
    .paddr_in                       (paddr),
    .pwdata_in                      (pwdata),
    .pstrb_in                       (pstrb),
    .prdata_out                     (prdata),
    .pready_out                     (pready),
    .pslverr_out                    (pslverr),
    .stretch_cycles_out             (stretch),
    .program_memory_mapped_out      (mapped),
    .lower_half_program_ok_out      (lower_ok),
    .page_window_program_ok_out     (window_ok),
    .ram_base_out                   (ram_base),
    .ram_high_align_out             (high_align)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one idle edge follows every transfer so no request signal is driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= st;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [4:0] outs(input logic [7:0] v);
    logic ext;
    ext = mode inside {MMR_MODE_NORM_EXP, MMR_MODE_EMUL_EXP, MMR_MODE_SPEC_EXP, MMR_MODE_SPEC_TEST};
    return {ext ? v[3:2] : 2'b00, v[0], v[0] & ~v[1], v[0]};
  endfunction

  task automatic do_reset(input mmr_mode_t m, input logic [2:0] ram);
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    mode     <= m;
    sw       <= {1'b0, 2'($urandom), ram, 1'($urandom)};
    strap    <= 1'($urandom);
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    misc_m = {4'h0, 2'b11, 1'b0, strap};
    locked = 1'b0;
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    logic [7:0]  d;
    logic [4:0]  old;
    logic [7:0]  p;
    int          eb;
    rst_n_in = 1'b0;
    mode = MMR_MODE_NORM_SINGLE;
    sw = '0;
    strap = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    void'($urandom(45614));
    for (int i = 0; i < 8; i++) begin
      do_reset(mmr_mode_t'(i), i[2:0]);
      apb(1'b0, 12'h000, 8'h00, 4'h0, rd, err);
      chk("misc reset", rd, {24'h0, misc_m});
      chk("outputs reset", outs_vec, outs(misc_m));
      chk("ram base", ram_base, base_tab[i]);
      chk("high align", high_align, 32'h1);
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, ro_addr[k], 8'($urandom), 4'hf, rd, err);
        apb(1'b0, ro_addr[k], 8'h00, 4'h0, rd, err);
        if (k == 2)
          chk("size reg", rd, {24'h0, sw[0], 1'b0, sw[5:4], 1'b0, sw[3:1]});
        else
          chk("test reg", rd, 32'h0);
      end
      apb(1'b1, 12'h020, 8'hff, 4'hf, rd, err);
      chk("unmapped error", err, 32'h1);
      // a write without its low strobe must neither land nor arm the lock
      apb(1'b1, 12'h000, 8'($urandom), 4'he, rd, err);
      apb(1'b0, 12'h000, 8'h00, 4'h0, rd, err);
      chk("misc strobe off", rd, {24'h0, misc_m});
      for (int k = 0; k < 4; k++) begin
        d = {4'($urandom), k[1:0], 2'($urandom)};
        old = outs(misc_m);
        apb(1'b1, 12'h000, d, 4'hf, rd, err);
        if (!locked)
          misc_m = {4'h0, d[3:0]};
        if (mode < MMR_MODE_SPEC_SINGLE)
          locked = 1'b1;
        #1 chk("outputs same cycle", outs_vec, old);
        @(posedge clock_in);
        #1 chk("outputs next cycle", outs_vec, outs(misc_m));
        apb(1'b0, 12'h000, 8'h00, 4'h0, rd, err);
        chk("misc readback", rd, {24'h0, misc_m});
      end
      // move the RAM: low align on even codes, high align on odd ones
      p = {5'($urandom), 2'($urandom), i[0]};
      apb(1'b1, 12'h010, p, 4'hf, rd, err);
      apb(1'b0, 12'h010, 8'h00, 4'h0, rd, err);
      eb = {p[7:3], 11'h000} & ~(region_tab[i] - 1);
      if (p[0])
        eb += region_tab[i] - (i + 1) * 2048;
      chk("ram position", rd, {24'h0, p & 8'hf9});
      chk("ram base moved", ram_base, eb[15:0]);
      chk("high align moved", high_align, {31'h0, p[0]});
      $display("test mode %0d done", i);
    end
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    $display("Error watchdog expected end seen hang");
    stop_test;
  end
endmodule
